// ### verilog/timer_clk_clr_pkg.sv
// Constants and types for the timer count-clock and counter-clear select block
package timer_clk_clr_pkg;

  // ==========================================================================
  // Channel counts and widths
  localparam int NUM_CH = 5;
  localparam int NUM_SUB5 = 3;
  localparam int DIV_W = 10;
  localparam int ADDR_W = 8;
  localparam int NUM_PINS = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL_BASE = 8'h00;
  localparam logic [7:0] OFF_SUB5_BASE = 8'h14;
  localparam logic [7:0] OFF_SYNC = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  localparam logic [7:0] REG_STRIDE = 8'h04;

  // ==========================================================================
  // Field layout of a channel control register
  localparam int PSC_LSB = 0;
  localparam int EDGE_LSB = 3;
  localparam int CLR_LSB = 5;
  localparam int CLR_MSB = 7;
  localparam int CTRL_W = 8;
  localparam int SUB5_W = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] SUB5_RESET = 2'h0;
  localparam logic [4:0] SYNC_RESET = 5'h00;
  localparam logic [7:0] CTRL_MASK_NARROW = 8'h7f;

  // ==========================================================================
  // Clear-source codes and edge codes
  localparam logic [2:0] CLR_ON_A = 3'h1;
  localparam logic [2:0] CLR_ON_B = 3'h2;
  localparam logic [2:0] CLR_ON_C = 3'h5;
  localparam logic [2:0] CLR_ON_D = 3'h6;
  localparam logic [1:0] CLR_SYNC_LOW = 2'h3;
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;

  // ==========================================================================
  // Log2 of prescale ratios
  localparam int LOG_D4 = 2;
  localparam int LOG_D16 = 4;
  localparam int LOG_D64 = 6;
  localparam int LOG_D256 = 8;
  localparam int LOG_D1024 = 10;

  typedef enum logic [3:0] {
    SRC_D1, SRC_D4, SRC_D16, SRC_D64, SRC_D256, SRC_D1024,
    SRC_EXT_A, SRC_EXT_B, SRC_EXT_C, SRC_EXT_D, SRC_OVF
  } count_src_e;

endpackage

// ### verilog/timer_clk_clr_select.sv
// Count-clock source and counter-clear source selection for a six-channel timer
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps

module timer_clk_clr_select (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [timer_clk_clr_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // External clock pins A..D
  input wire logic [timer_clk_clr_pkg::NUM_PINS-1:0] ext_clock_pin_i,
  // Events from the rest of the timer, channels 0..4
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_a_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_b_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_c_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_d_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] buffer_c_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] buffer_d_i,
  input wire logic ch2_wrap_i,
  input wire logic [1:0] phase_mode_i,
  // Count enables and clears
  output logic [timer_clk_clr_pkg::NUM_CH-1:0] count_en_o,
  output logic [timer_clk_clr_pkg::NUM_SUB5-1:0] count_en5_o,
  output logic [timer_clk_clr_pkg::NUM_CH-1:0] clear_o
);
  import timer_clk_clr_pkg::*;

  // ==========================================================================
  // Register storage
  logic [CTRL_W-1:0] channel_control_reg [NUM_CH];
  logic [SUB5_W-1:0] sub5_prescale [NUM_SUB5];
  logic [NUM_CH-1:0] sync_select_reg;
  logic [31:0] rd_data;
  logic rd_err;

  // ==========================================================================
  // APB decode
  wire setup_phase = psel_i & ~penable_i;
  wire access_phase = psel_i & penable_i;
  logic [NUM_CH-1:0] hit_ctrl;
  logic [NUM_SUB5-1:0] hit_sub5;
  wire hit_sync = (paddr_i == OFF_SYNC);
  wire hit_status = (paddr_i == OFF_STATUS);
  wire mapped = (|hit_ctrl) | (|hit_sub5) | hit_sync | hit_status;
  wire wr_en = access_phase & pwrite_i & mapped;

  // ==========================================================================
  // Pin synchronisers and edge detection
  // Two flops guard against metastability on the asynchronous pins;
  // the third stage only remembers the last level for edge detection.
  logic [NUM_PINS-1:0] pin_meta;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_prev;
  wire [NUM_PINS-1:0] pin_rise = pin_sync & ~pin_prev;
  wire [NUM_PINS-1:0] pin_fall = ~pin_sync & pin_prev;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      pin_prev <= '0;
    end else begin
      pin_meta <= ext_clock_pin_i;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  // ==========================================================================
  // Shared prescaler
  // One divider feeds every ratio so that all internal ticks stay phase
  // aligned; settings are assumed static while a counter runs.
  logic [DIV_W-1:0] div_cnt;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_W'(1);
    end
  end

  // Rising tick when the low bits are all ones, falling tick half a period
  // earlier; both together halve the period.
  function automatic logic div_tick(input logic [DIV_W-1:0] d, input int lg,
                                    input logic [1:0] edge_sel);
    logic [DIV_W-1:0] m;
    logic rise;
    logic fall;
    m = DIV_W'((1 << lg) - 1);
    rise = ((d & m) == m);
    fall = ((d & m) == (m >> 1));
    if (edge_sel[1]) begin
      div_tick = rise | fall;
    end else if (edge_sel == EDGE_FALL) begin
      div_tick = fall;
    end else begin
      div_tick = rise;
    end
  endfunction

  function automatic logic pin_tick(input logic r, input logic f,
                                    input logic [1:0] edge_sel);
    if (edge_sel[1]) begin
      pin_tick = r | f;
    end else if (edge_sel == EDGE_FALL) begin
      pin_tick = f;
    end else begin
      pin_tick = r;
    end
  endfunction

  // ==========================================================================
  // Per-channel source tables
  // Low codes are shared; the upper half differs for channels 0, 1 and 2, and channels 3 and 4 share one
  function automatic count_src_e map_src(input int ch, input logic [2:0] code);
    map_src = SRC_D1;
    if (!code[2]) begin
      case (code[1:0])
        2'h0: map_src = SRC_D1;
        2'h1: map_src = SRC_D4;
        2'h2: map_src = SRC_D16;
        default: map_src = SRC_D64;
      endcase
    end else if (ch == 0) begin
      case (code[1:0])
        2'h0: map_src = SRC_EXT_A;
        2'h1: map_src = SRC_EXT_B;
        2'h2: map_src = SRC_EXT_C;
        default: map_src = SRC_EXT_D;
      endcase
    end else if (ch == 1) begin
      case (code[1:0])
        2'h0: map_src = SRC_EXT_A;
        2'h1: map_src = SRC_EXT_B;
        2'h2: map_src = SRC_D256;
        default: map_src = SRC_OVF;
      endcase
    end else if (ch == 2) begin
      case (code[1:0])
        2'h0: map_src = SRC_EXT_A;
        2'h1: map_src = SRC_EXT_B;
        2'h2: map_src = SRC_EXT_C;
        default: map_src = SRC_D1024;
      endcase
    end else begin
      case (code[1:0])
        2'h0: map_src = SRC_D256;
        2'h1: map_src = SRC_D1024;
        2'h2: map_src = SRC_EXT_A;
        default: map_src = SRC_EXT_B;
      endcase
    end
  endfunction

  // ==========================================================================
  // Clear events
  // A channel waiting on a synchronous clear never acts as a source
  // itself, so the path through sync_source cannot loop back.
  logic [NUM_CH-1:0] own_clear;
  logic [NUM_CH-1:0] sync_clear;
  logic [NUM_CH-1:0] next_count_en;
  wire sync_source = |(own_clear & sync_select_reg);

  // ==========================================================================
  // Channels 0..4
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    wire [2:0] psc = channel_control_reg[c][PSC_LSB +: 3];
    wire [1:0] edge_sel = channel_control_reg[c][EDGE_LSB +: 2];
    wire [2:0] clr = channel_control_reg[c][CLR_MSB:CLR_LSB];
    count_src_e src;
    assign src = map_src(c, psc);
    // Buffer mode suppresses C/D events entirely
    wire evt_c = match_c_i[c] & ~buffer_c_i[c];
    wire evt_d = match_d_i[c] & ~buffer_d_i[c];
    wire in_phase = ((c == 1) && phase_mode_i[0]) || ((c == 2) && phase_mode_i[1]);
    logic en;

    assign own_clear[c] = ((clr == CLR_ON_A) & match_a_i[c])
                        | ((clr == CLR_ON_B) & match_b_i[c])
                        | ((clr == CLR_ON_C) & evt_c)
                        | ((clr == CLR_ON_D) & evt_d);
    assign sync_clear[c] = (clr[1:0] == CLR_SYNC_LOW) & sync_select_reg[c]
                         & sync_source;

    always_comb begin
      case (src)
        SRC_D1: en = 1'b1; // Edge field has no effect at full rate
        SRC_D4: en = div_tick(div_cnt, LOG_D4, edge_sel);
        SRC_D16: en = div_tick(div_cnt, LOG_D16, edge_sel);
        SRC_D64: en = div_tick(div_cnt, LOG_D64, edge_sel);
        SRC_D256: en = div_tick(div_cnt, LOG_D256, edge_sel);
        SRC_D1024: en = div_tick(div_cnt, LOG_D1024, edge_sel);
        SRC_EXT_A: en = pin_tick(pin_rise[0], pin_fall[0], edge_sel);
        SRC_EXT_B: en = pin_tick(pin_rise[1], pin_fall[1], edge_sel);
        SRC_EXT_C: en = pin_tick(pin_rise[2], pin_fall[2], edge_sel);
        SRC_EXT_D: en = pin_tick(pin_rise[3], pin_fall[3], edge_sel);
        SRC_OVF: en = ch2_wrap_i;
        default: en = 1'b0;
      endcase
    end

    // The phase counter owns the counter, so this select is silenced
    assign next_count_en[c] = en & ~in_phase;
  end

  // ==========================================================================
  // Channel 5 sub-counters
  // Channel 5 has no edge field, so its ticks always use the rising
  // phase of the shared divider.
  logic [NUM_SUB5-1:0] next_count_en5;

  for (genvar s = 0; s < NUM_SUB5; s++) begin : g_sub5
    always_comb begin
      case (sub5_prescale[s])
        2'h0: next_count_en5[s] = 1'b1;
        2'h1: next_count_en5[s] = div_tick(div_cnt, LOG_D4, EDGE_RISE);
        2'h2: next_count_en5[s] = div_tick(div_cnt, LOG_D16, EDGE_RISE);
        default: next_count_en5[s] = div_tick(div_cnt, LOG_D64, EDGE_RISE);
      endcase
    end
  end

  // ==========================================================================
  // Output registers
  // One flop on every strobe keeps the outputs glitch free; the price is
  // one cycle of latency after each event.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_en_o <= '0;
      count_en5_o <= '0;
      clear_o <= '0;
    end else begin
      count_en_o <= next_count_en;
      count_en5_o <= next_count_en5;
      clear_o <= own_clear | sync_clear;
    end
  end

  // ==========================================================================
  // Register writes
  // Writes land only in the access phase; status is read-only and
  // ignores writes without raising an error.
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ctrl_reg
    assign hit_ctrl[c] = (paddr_i == OFF_CTRL_BASE + ADDR_W'(c) * REG_STRIDE);
    // Bit 7 does not exist on channels 1 and 2
    wire [CTRL_W-1:0] wmask = ((c == 1) || (c == 2)) ? CTRL_MASK_NARROW : 8'hff;

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        channel_control_reg[c] <= CTRL_RESET;
      end else if (wr_en && hit_ctrl[c]) begin
        channel_control_reg[c] <= pwdata_i[CTRL_W-1:0] & wmask;
      end
    end
  end

  for (genvar s = 0; s < NUM_SUB5; s++) begin : g_sub5_reg
    assign hit_sub5[s] = (paddr_i == OFF_SUB5_BASE + ADDR_W'(s) * REG_STRIDE);

    always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
        sub5_prescale[s] <= SUB5_RESET;
      end else if (wr_en && hit_sub5[s]) begin
        sub5_prescale[s] <= pwdata_i[SUB5_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      sync_select_reg <= SYNC_RESET;
    end else if (wr_en && hit_sync) begin
      sync_select_reg <= pwdata_i[NUM_CH-1:0];
    end
  end

  // ==========================================================================
  // Read mux, captured during the setup phase
  // Status: synchronised pins, then clear strobes, then count strobes
  always_comb begin
    rd_data = 32'h0000_0000;
    for (int c = 0; c < NUM_CH; c++) begin
      if (hit_ctrl[c]) begin
        rd_data[CTRL_W-1:0] = channel_control_reg[c];
      end
    end
    for (int s = 0; s < NUM_SUB5; s++) begin
      if (hit_sub5[s]) begin
        rd_data[SUB5_W-1:0] = sub5_prescale[s];
      end
    end
    if (hit_sync) begin
      rd_data[NUM_CH-1:0] = sync_select_reg;
    end
    if (hit_status) begin
      rd_data[NUM_PINS-1:0] = pin_sync;
      rd_data[NUM_PINS +: NUM_CH] = clear_o;
      rd_data[NUM_PINS + NUM_CH +: NUM_CH] = count_en_o;
    end
  end

  assign rd_err = ~mapped;

  // Registering the answer in setup keeps prdata a flop; zero wait states
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup_phase) begin
      prdata_o <= rd_data;
      pslverr_o <= rd_err;
    end
  end

  assign pready_o = 1'b1;

endmodule

// ### bench/timer_clk_clr_select_checker.sv
// Assertion checker for the count-clock and counter-clear select block
`timescale 1ns/1ps
module timer_clk_clr_select_checker (
  // Clock, reset and register bus
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [timer_clk_clr_pkg::ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  // Timer events and block outputs
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_a_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_b_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_c_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] match_d_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] buffer_c_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] buffer_d_i,
  input wire logic [1:0] phase_mode_i,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] count_en_o,
  input wire logic [timer_clk_clr_pkg::NUM_CH-1:0] clear_o
);
  import timer_clk_clr_pkg::*;
  logic [7:0] ctrl0;
  logic [2:0] cfg_age;
  logic wr_ctrl0;
  logic [NUM_CH-1:0] cause;

  // ====================
  // Shadow of channel 0 control; age keeps rate checks off until the setting settles
  assign wr_ctrl0 = psel_i && penable_i && pwrite_i && (paddr_i == OFF_CTRL_BASE);
  assign cause = match_a_i | match_b_i | (match_c_i & ~buffer_c_i)
      | (match_d_i & ~buffer_d_i);
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl0 <= CTRL_RESET;
      cfg_age <= 3'h0;
    end else if (wr_ctrl0) begin
      ctrl0 <= pwdata_i[7:0];
      cfg_age <= 3'h0;
    end else if (cfg_age != 3'h7) begin
      cfg_age <= cfg_age + 3'h1;
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_cause_a;
    match_a_i[0] && ctrl0[7:5] == CLR_ON_A;
  endsequence
  sequence s_cause_c;
    match_c_i[0] && !buffer_c_i[0] && ctrl0[7:5] == CLR_ON_C;
  endsequence
  chk_clear_on_a: assert property (s_cause_a |=> clear_o[0])
    else $error("clear on register A missing");
  chk_clear_on_c: assert property (s_cause_c |=> clear_o[0])
    else $error("clear on register C missing");
  chk_buffer_blocks_c: assert property (ctrl0[7:5] == CLR_ON_C && buffer_c_i[0]
      |=> !clear_o[0])
    else $error("buffered register C cleared the counter");
  chk_idle_codes: assert property (ctrl0[6:5] == 2'h0 && $past(ctrl0[6:5]) == 2'h0
      |-> !clear_o[0])
    else $error("clear seen with clearing disabled");
  chk_clear_cause: assert property (|clear_o |-> $past(|cause))
    else $error("clear without any source event");
  chk_phase_mutes: assert property ($past(phase_mode_i[0]) && phase_mode_i[0]
      |-> !count_en_o[1])
    else $error("channel 1 stepped in phase counting");
  chk_div1_steps: assert property (cfg_age == 3'h7 && ctrl0[2:0] == 3'h0
      |-> count_en_o[0])
    else $error("divide by one missed a step");
  chk_div4_gap: assert property (cfg_age == 3'h7 && ctrl0[4:0] == 5'h01 && count_en_o[0]
      |-> $past(count_en_o[0], 4) && !$past(count_en_o[0]) && !$past(count_en_o[0], 2)
      && !$past(count_en_o[0], 3))
    else $error("divide by four spacing wrong");
endmodule

bind timer_clk_clr_select timer_clk_clr_select_checker timer_clk_clr_select_checker_inst (
  .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .match_a_i(match_a_i),
  .match_b_i(match_b_i), .match_c_i(match_c_i), .match_d_i(match_d_i),
  .buffer_c_i(buffer_c_i), .buffer_d_i(buffer_d_i), .phase_mode_i(phase_mode_i),
  .count_en_o(count_en_o), .clear_o(clear_o)
);

// ### bench/timer_clock_and_clear_select_tb_top.sv
// Self-checking testbench for the count-clock and counter-clear select block
`timescale 1ns/1ps
module timer_clock_and_clear_select_tb_top;
  import timer_clk_clr_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic psel_i, penable_i, pwrite_i, pready_o, pslverr_o, rerr;
  logic [ADDR_W-1:0] paddr_i;
  logic [31:0] pwdata_i, prdata_o, rdata;
  logic [NUM_PINS-1:0] ext_clock_pin_i = 4'h0;
  logic [NUM_CH-1:0] match_a_i, match_b_i, match_c_i, match_d_i;
  logic [NUM_CH-1:0] buffer_c_i, buffer_d_i, count_en_o, clear_o;
  logic ch2_wrap_i = 1'b0;
  logic [1:0] phase_mode_i;
  logic [NUM_SUB5-1:0] count_en5_o;
  logic [11:0] cyc = 12'h000;
  int num_errors = 0;
  int checked = 0;

  timer_clk_clr_select timer_clk_clr_select_inst (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .ext_clock_pin_i(ext_clock_pin_i),
    .match_a_i(match_a_i), .match_b_i(match_b_i), .match_c_i(match_c_i),
    .match_d_i(match_d_i), .buffer_c_i(buffer_c_i), .buffer_d_i(buffer_d_i),
    .ch2_wrap_i(ch2_wrap_i), .phase_mode_i(phase_mode_i), .count_en_o(count_en_o),
    .count_en5_o(count_en5_o), .clear_o(clear_o)
  );

  always #2 clk_i = ~clk_i;

  // Pins A..D run at periods 8, 16, 32, 64 so a wrong pin choice shows in the count
  always @(posedge clk_i) begin
    cyc <= cyc + 12'h001;
    ext_clock_pin_i <= cyc[5:2];
    ch2_wrap_i <= (cyc[4:0] == 5'h00);
  end

  // ====================
  // Bus, compare and closing tasks
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cmp_count(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task tally_and_finish;
    if (num_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ====================
  // Scenarios
  task automatic t_regs;
    for (int i = 0; i < 9; i++) begin
      apb(1'b1, 8'(i * 4), 32'hffff_ffff);
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      cmp_val("readback", (i == 1 || i == 2) ? 32'h0000_007f : (i < 5) ? 32'h0000_00ff
          : (i < 8) ? 32'h0000_0003 : 32'h0000_001f, rdata);
      cmp_val("no error", 32'h0000_0000, {31'h0, rerr});
    end
    apb(1'b0, 8'h28, 32'h0000_0000);
    cmp_val("unmapped", 32'h0000_0001, {31'h0, rerr});
    @(posedge clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0000_0000);
      cmp_val("reset value", 32'h0000_0000, rdata);
    end
    apb(1'b0, OFF_STATUS, 32'h0000_0000);
    cmp_val("status", 32'h0000_3e00, rdata & 32'hffff_fff0);
    #1;
    cmp_val("steps after reset", 32'h0000_00ff, {count_en5_o, count_en_o});
  endtask

  task automatic t_clears;
    int c;
    logic exp;
    for (int bf = 0; bf < 2; bf++) begin
      buffer_c_i <= bf ? 5'h1f : 5'h00;
      buffer_d_i <= bf ? 5'h1f : 5'h00;
      for (int ch = 0; ch < 5; ch++) begin
        for (int code = 0; code < 8; code++) begin
          c = (ch == 1 || ch == 2) ? code % 4 : code;
          apb(1'b1, 8'(ch * 4), 32'(c * 32 + 1));
          for (int s = 0; s < 4; s++) begin
            exp = (c == 1 && s == 0) || (c == 2 && s == 1) || (bf == 0 && s > 1 && c == s + 3);
            @(posedge clk_i);
            {match_d_i, match_c_i, match_b_i, match_a_i} <= 20'h0_0001 << (s * 5 + ch);
            @(posedge clk_i);
            {match_d_i, match_c_i, match_b_i, match_a_i} <= 20'h0_0000;
            #1;
            cmp_val("clear", 32'(exp) << ch, 32'(clear_o));
          end
        end
      end
    end
    buffer_c_i <= 5'h00;
    buffer_d_i <= 5'h00;
  endtask

  task automatic t_sync;
    logic [4:0] sv [3];
    logic [4:0] ex [3];
    sv = '{5'h09, 5'h1b, 5'h1a};
    ex = '{5'h09, 5'h1b, 5'h01};
    apb(1'b1, 8'h00, 32'h0000_0021);
    apb(1'b1, 8'h04, 32'h0000_0061);
    apb(1'b1, 8'h0c, 32'h0000_0061);
    apb(1'b1, 8'h10, 32'h0000_00e1);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFF_SYNC, 32'(sv[k]));
      @(posedge clk_i);
      match_a_i <= 5'h01;
      @(posedge clk_i);
      match_a_i <= 5'h00;
      #1;
      cmp_val("sync clear", 32'(ex[k]), 32'(clear_o));
    end
    apb(1'b1, OFF_SYNC, 32'h0000_0000);
  endtask

  function automatic int exp_count(int k, int code, int edg, int ph);
    int lg;
    int pin;
    int n;
    if (k >= 5) return 2048 >> (2 * (code % 4));
    if ((k == 1 && ph % 2 == 1) || (k == 2 && ph > 1)) return 0;
    if (k == 1 && code == 7) return 64;
    lg = 2 * code;
    pin = -1;
    if ((k == 0 && code > 3) || (k == 1 && code > 3 && code < 6)) pin = code - 4;
    if (k == 2 && code > 3 && code < 7) pin = code - 4;
    if (k == 1 && code == 6) lg = 8;
    if (k == 2 && code == 7) lg = 10;
    if (k > 2 && code > 5) pin = code - 6;
    n = (pin >= 0) ? 2048 >> (3 + pin) : 2048 >> lg;
    if (pin < 0 && lg == 0) return n;
    return (edg >= 2) ? 2 * n : n;
  endfunction

  task automatic t_prescale;
    logic [31:0] cnt [8];
    int ex;
    for (int p = 0; p < 25; p++) begin
      phase_mode_i <= (p == 24) ? 2'h3 : 2'h0;
      for (int ch = 0; ch < 5; ch++) apb(1'b1, 8'(ch * 4), 32'(p % 8 + (p / 8) * 8));
      for (int u = 0; u < 3; u++) apb(1'b1, 8'(OFF_SUB5_BASE + u * 4), 32'(p % 4));
      repeat (24) @(posedge clk_i);
      cnt = '{default: 0};
      repeat (2048) begin
        @(posedge clk_i);
        #1;
        for (int k = 0; k < 8; k++) cnt[k] += (k < 5) ? count_en_o[k] : count_en5_o[k - 5];
      end
      for (int k = 0; k < 8; k++) begin
        ex = exp_count(k, p % 8, p / 8, (p == 24) ? 3 : 0);
        cmp_count("step count", ex, cnt[k]);
      end
    end
  endtask

  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {match_a_i, match_b_i, match_c_i, match_d_i, buffer_c_i, buffer_d_i} = '0;
    phase_mode_i = 2'h0;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t_regs();
    t_clears();
    t_sync();
    t_prescale();
    tally_and_finish();
  end

  // Run needs about 53000 cycles; a hang is cut off well past that
  initial begin
    repeat (90000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule
